/* hw/lcd_cmd_pkg.sv */
package lcd_cmd_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFF_HOST_CMD   = 12'h000;
  localparam logic [11:0] OFF_HOST_DATA  = 12'h004;
  localparam logic [11:0] OFF_POINTERS   = 12'h008;
  localparam logic [11:0] OFF_STEP_CTRL  = 12'h00C;
  localparam logic [11:0] OFF_WINDOW     = 12'h010;
  localparam logic [11:0] OFF_PANEL_CFG  = 12'h014;
  localparam logic [11:0] OFF_NVM        = 12'h018;
  localparam logic [11:0] OFF_LINE_RATE  = 12'h01C;
  // ****************************************
  // Command codes and masks
  // ****************************************
  localparam logic [7:0] CMD_BIAS_POT    = 8'h81;
  localparam logic [7:0] CMD_NVM_OPCTL   = 8'hB8;
  localparam logic [7:0] CMD_NVM_MASK    = 8'hB9;
  localparam logic [7:0] CMD_SYS_RESET   = 8'hE2;
  localparam logic [7:0] CMD_WIN_SC      = 8'hF4;
  localparam logic [7:0] CMD_WIN_SR      = 8'hF5;
  localparam logic [7:0] CMD_WIN_EC      = 8'hF6;
  localparam logic [7:0] CMD_WIN_ER      = 8'hF7;
  localparam logic [6:0] CMD_WIN_EN_HI   = 7'h7C;
  localparam logic [5:0] CMD_PUMP_HI     = 6'h0B;
  localparam logic [4:0] CMD_STEP_HI     = 5'h11;
  localparam logic [5:0] CMD_RATE_HI     = 6'h28;
  localparam logic [4:0] CMD_MAP_HI      = 5'h18;
  localparam logic [3:0] CMD_ROW_LO_HI   = 4'h6;
  localparam logic [3:0] CMD_ROW_HI_HI   = 4'h7;
  localparam logic [2:0] CMD_COL_HI      = 3'h0;
  localparam int         NVM_SEL_BIT     = 3;
  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [4:0] COL_MAX         = 5'h1F;
  localparam logic [6:0] ROW_MAX         = 7'h7F;
  localparam logic [1:0] RST_PUMP        = 2'h3;
  localparam logic [7:0] RST_BIAS_POT    = 8'h4E;
  localparam logic [7:0] BIAS_POT_MAX    = 8'hC1;
  localparam logic [2:0] RST_STEP        = 3'h1;
  localparam logic [7:0] RST_NVM_OPCTL   = 8'h10;
  localparam logic [1:0] RST_LINE_RATE   = 2'h0;
  localparam logic [2:0] RST_MAP         = 3'h0;
  // Line rate table, tens of lines per second
  localparam logic [15:0] RATE_NORMAL [4] = '{16'h058C, 16'h06C2, 16'h083E, 16'h0A0A};
  localparam logic [15:0] RATE_ONOFF  [4] = '{16'h023A, 16'h02BC, 16'h0352, 16'h0410};
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARG    = 2'b01
  } dec_state_t;
endpackage

/* hw/lcd_command_decoder.sv */
`timescale 1ns/1ps
module lcd_command_decoder #(
  parameter int COL_W = 5,
  parameter int ROW_W = 7
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_onoff_mode,
  input  wire logic [7:0]  i_mux_rate,
  output logic      [4:0]  o_ram_column,
  output logic      [6:0]  o_ram_row,
  output logic             o_com_mirror,
  output logic             o_icon_show,
  output logic      [1:0]  o_pump_control_field,
  output logic      [7:0]  o_bias_pot_value,
  output logic      [15:0] o_line_rate
);
  import lcd_cmd_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  logic       acc;
  logic       wr_cmd;
  logic       data_acc;
  logic [7:0] cb;
  assign acc      = psel & penable;
  assign pready   = 1'b1;
  assign cb       = pwdata[7:0];
  // Command register is select low, data register select high
  assign wr_cmd   = acc & pwrite & (paddr == OFF_HOST_CMD);
  assign data_acc = acc & (paddr == OFF_HOST_DATA);

  // ****************************************
  // Control state
  // ****************************************
  dec_state_t state_reg;
  logic [7:0] pend_reg;
  logic [4:0] column_pointer_reg;
  logic [6:0] row_pointer_reg;
  logic [1:0] pump_reg;
  logic [7:0] shared_pot_reg;
  logic [2:0] step_reg;
  logic       win_en_reg;
  logic [4:0] win_sc_reg;
  logic [4:0] win_ec_reg;
  logic [6:0] win_sr_reg;
  logic [6:0] win_er_reg;
  logic [7:0] nvm_op_reg;
  logic [7:0] nvm_aux_reg [4];
  logic [1:0] rate_reg;
  logic [2:0] map_reg;
  logic       nvm_sel;
  logic       soft_rst;
  assign nvm_sel  = nvm_op_reg[NVM_SEL_BIT];
  assign soft_rst = wr_cmd & (state_reg == ST_IDLE) & (cb == CMD_SYS_RESET);

  // Window bounds in force; off means full panel
  logic [4:0] lo_c;
  logic [4:0] hi_c;
  logic [6:0] lo_r;
  logic [6:0] hi_r;
  assign lo_c = win_en_reg ? win_sc_reg : 5'h00;
  assign hi_c = win_en_reg ? win_ec_reg : COL_MAX;
  assign lo_r = win_en_reg ? win_sr_reg : 7'h00;
  assign hi_r = win_en_reg ? win_er_reg : ROW_MAX;

  function automatic logic [6:0] row_step(input logic [6:0] r, input logic down,
                                          input logic [6:0] lo, input logic [6:0] hi);
    logic [6:0] n;
    n = r;
    if (down) begin
      n = (r == lo) ? hi : 7'(r - 7'h01);
    end else begin
      n = (r == hi) ? lo : 7'(r + 7'h01);
    end
    return n;
  endfunction

  // ****************************************
  // Command decoder
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
      pend_reg  <= 8'h00;
    end else if (wr_cmd) begin
      if (state_reg == ST_ARG) begin
        state_reg <= ST_IDLE;
      end else if (cb == CMD_BIAS_POT || cb == CMD_NVM_OPCTL || cb == CMD_NVM_MASK ||
                   (cb >= CMD_WIN_SC && cb <= CMD_WIN_ER)) begin
        state_reg <= ST_ARG;
        pend_reg  <= cb;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pump_reg   <= RST_PUMP;
      step_reg   <= RST_STEP;
      win_en_reg <= 1'b0;
      rate_reg   <= RST_LINE_RATE;
      map_reg    <= RST_MAP;
    end else if (soft_rst) begin
      pump_reg   <= RST_PUMP;
      step_reg   <= RST_STEP;
      win_en_reg <= 1'b0;
      rate_reg   <= RST_LINE_RATE;
      map_reg    <= RST_MAP;
    end else if (wr_cmd && state_reg == ST_IDLE) begin
      if (cb[7:2] == CMD_PUMP_HI) begin
        pump_reg <= cb[1:0];
      end
      if (cb[7:3] == CMD_STEP_HI) begin
        step_reg <= cb[2:0];
      end
      if (cb[7:1] == CMD_WIN_EN_HI) begin
        win_en_reg <= cb[0];
      end
      if (cb[7:2] == CMD_RATE_HI) begin
        rate_reg <= cb[1:0];
      end
      if (cb[7:3] == CMD_MAP_HI) begin
        map_reg <= cb[2:0];
      end
    end
  end

  // Two-byte argument handling
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shared_pot_reg <= RST_BIAS_POT;
      nvm_op_reg     <= RST_NVM_OPCTL;
      win_sc_reg     <= 5'h00;
      win_sr_reg     <= 7'h00;
      win_ec_reg     <= COL_MAX;
      win_er_reg     <= ROW_MAX;
      for (int i = 0; i < 4; i++) begin
        nvm_aux_reg[i] <= 8'h00;
      end
    end else if (soft_rst) begin
      shared_pot_reg <= RST_BIAS_POT;
      nvm_op_reg     <= RST_NVM_OPCTL;
      win_sc_reg     <= 5'h00;
      win_sr_reg     <= 7'h00;
      win_ec_reg     <= COL_MAX;
      win_er_reg     <= ROW_MAX;
    end else if (wr_cmd && state_reg == ST_ARG) begin
      case (pend_reg)
        CMD_BIAS_POT: begin
          if (!nvm_sel) shared_pot_reg <= cb;
        end
        CMD_NVM_MASK: begin
          if (nvm_sel) shared_pot_reg <= cb;
        end
        CMD_NVM_OPCTL: nvm_op_reg <= cb;
        CMD_WIN_SC, CMD_WIN_SR, CMD_WIN_EC, CMD_WIN_ER: begin
          if (nvm_sel) begin
            nvm_aux_reg[pend_reg[1:0]] <= cb;
          end else if (pend_reg == CMD_WIN_SC) begin
            win_sc_reg <= cb[4:0];
          end else if (pend_reg == CMD_WIN_SR) begin
            win_sr_reg <= cb[6:0];
          end else if (pend_reg == CMD_WIN_EC) begin
            win_ec_reg <= cb[4:0];
          end else begin
            win_er_reg <= cb[6:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Address pointers
  // ****************************************
  logic wrap;
  logic row_first;
  logic row_down;
  assign wrap      = step_reg[0];
  assign row_first = step_reg[1];
  assign row_down  = step_reg[2];

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      column_pointer_reg <= 5'h00;
      row_pointer_reg    <= 7'h00;
    end else if (soft_rst) begin
      column_pointer_reg <= 5'h00;
      row_pointer_reg    <= 7'h00;
    end else if (wr_cmd && state_reg == ST_IDLE) begin
      if (cb[7:5] == CMD_COL_HI) begin
        column_pointer_reg <= cb[4:0];
      end
      if (cb[7:4] == CMD_ROW_LO_HI) begin
        row_pointer_reg[3:0] <= cb[3:0];
      end
      if (cb[7:4] == CMD_ROW_HI_HI) begin
        row_pointer_reg[6:4] <= cb[2:0];
      end
    end else if (data_acc) begin
      if (!row_first) begin
        if (column_pointer_reg != hi_c) begin
          column_pointer_reg <= 5'(column_pointer_reg + 5'h01);
        end else if (wrap) begin
          column_pointer_reg <= lo_c;
          row_pointer_reg    <= row_step(row_pointer_reg, row_down, lo_r, hi_r);
        end
      end else begin
        if (row_pointer_reg != (row_down ? lo_r : hi_r)) begin
          row_pointer_reg <= row_step(row_pointer_reg, row_down, lo_r, hi_r);
        end else if (wrap) begin
          row_pointer_reg    <= row_down ? hi_r : lo_r;
          column_pointer_reg <= (column_pointer_reg == hi_c) ? lo_c :
                                5'(column_pointer_reg + 5'h01);
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [15:0] base_rate;
  logic [15:0] scaled_rate;
  always_comb begin
    base_rate = i_onoff_mode ? RATE_ONOFF[rate_reg] : RATE_NORMAL[rate_reg];
    // Scaling done here avoids a divider in the timing generator
    if (i_onoff_mode || i_mux_rate > 8'h55) begin
      scaled_rate = base_rate;
    end else if (i_mux_rate > 8'h40) begin
      scaled_rate = 16'((32'(base_rate) * 2) / 3);
    end else if (i_mux_rate > 8'h2B) begin
      scaled_rate = 16'(base_rate >> 1);
    end else if (i_mux_rate > 8'h20) begin
      scaled_rate = 16'(32'(base_rate) / 3);
    end else begin
      scaled_rate = 16'(base_rate >> 2);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_line_rate <= 16'h0000;
    end else begin
      o_line_rate <= scaled_rate;
    end
  end

  // Segment mirror only changes host addressing, not the image
  assign o_ram_column = map_reg[1] ? 5'(COL_MAX - column_pointer_reg) : column_pointer_reg;
  assign o_ram_row            = row_pointer_reg;
  assign o_com_mirror         = map_reg[2];
  assign o_icon_show          = map_reg[0];
  assign o_pump_control_field = pump_reg;
  assign o_bias_pot_value     = shared_pot_reg;
  assign pslverr              = 1'b0;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      OFF_POINTERS:  prdata = {17'h0_0000, row_pointer_reg, 3'h0, column_pointer_reg};
      OFF_STEP_CTRL: prdata = {27'h000_0000, win_en_reg, 1'b0, step_reg};
      OFF_WINDOW:    prdata = {1'b0, win_er_reg, 3'h0, win_ec_reg, 1'b0, win_sr_reg,
                               3'h0, win_sc_reg};
      OFF_PANEL_CFG: prdata = {17'h0_0000, map_reg, rate_reg, pump_reg, shared_pot_reg};
      OFF_NVM:       prdata = {24'h00_0000, nvm_op_reg};
      OFF_LINE_RATE: prdata = {16'h0000, o_line_rate};
      default:       prdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_COL_LOAD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_IDLE && cb[7:5] == 3'h0 |=> column_pointer_reg == $past(cb[4:0]))
    else $error("column load failed");
  AST_PUMP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_IDLE && cb[7:2] == 6'h0B |=> pump_reg == $past(cb[1:0]))
    else $error("pump load failed");
  AST_ROW_HI: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_IDLE && cb[7:4] == 4'h7 |=> row_pointer_reg[6:4] == $past(cb[2:0]))
    else $error("row high load failed");
  AST_BIAS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_ARG && pend_reg == CMD_BIAS_POT && !nvm_sel
    |=> shared_pot_reg == $past(cb))
    else $error("bias pot load failed");
  AST_NO_WRAP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    data_acc && !wr_cmd && !wrap && !row_first && column_pointer_reg == hi_c
    |=> $stable(column_pointer_reg))
    else $error("column moved without wrap");
  AST_COL_STEP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    data_acc && !wr_cmd && !row_first && column_pointer_reg != hi_c
    |=> column_pointer_reg == 5'($past(column_pointer_reg) + 5'h01) && $stable(row_pointer_reg))
    else $error("column step failed");
  AST_RESET: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    soft_rst |=> nvm_op_reg == 8'h10 && step_reg == 3'h1 && win_er_reg == 7'h7F)
    else $error("soft reset failed");
  AST_MIRROR: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    map_reg[1] |-> o_ram_column + column_pointer_reg == 5'h1F)
    else $error("segment mirror wrong");
  AST_ROW_LO: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_IDLE && cb[7:4] == CMD_ROW_LO_HI
    |=> row_pointer_reg[3:0] == $past(cb[3:0]))
    else $error("row low load failed");
  AST_STEP_LOAD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_IDLE && cb[7:3] == CMD_STEP_HI
    |=> step_reg == $past(cb[2:0]))
    else $error("step control load failed");
  AST_ROW_DOWN: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    data_acc && row_first && row_down && row_pointer_reg != lo_r
    |=> row_pointer_reg == 7'($past(row_pointer_reg) - 7'h01))
    else $error("row down step failed");
  AST_WIN_EN: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_IDLE && cb[7:1] == CMD_WIN_EN_HI
    |=> win_en_reg == $past(cb[0]))
    else $error("window enable load failed");
  AST_NVM_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_ARG && pend_reg == CMD_WIN_SC && nvm_sel
    |=> $stable(win_sc_reg))
    else $error("window bound changed in nvm mode");
  AST_MASK: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_ARG && pend_reg == CMD_NVM_MASK && nvm_sel
    |=> shared_pot_reg == $past(cb))
    else $error("write mask load failed");
  AST_NVM_OP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_ARG && pend_reg == CMD_NVM_OPCTL
    |=> nvm_op_reg == $past(cb))
    else $error("nvm op control load failed");
  AST_RATE_FULL: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !i_onoff_mode && i_mux_rate > 8'h55
    |=> o_line_rate == $past(RATE_NORMAL[rate_reg]))
    else $error("full line rate wrong");
  AST_ONOFF: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_onoff_mode
    |=> o_line_rate == $past(RATE_ONOFF[rate_reg]))
    else $error("on off line rate wrong");
  AST_WRAP_STEP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    data_acc && !row_first && wrap && column_pointer_reg == hi_c
    |=> column_pointer_reg == $past(lo_c))
    else $error("column wrap failed");
  AST_MAP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_cmd && state_reg == ST_IDLE && cb[7:3] == CMD_MAP_HI
    |=> o_com_mirror == $past(cb[2]) && o_icon_show == $past(cb[0]))
    else $error("mapping load failed");
  COV_DATA: cover property (@(posedge i_mclk) data_acc);
  COV_WRAP: cover property (@(posedge i_mclk) data_acc && wrap && column_pointer_reg == hi_c);
  COV_NVM: cover property (@(posedge i_mclk) wr_cmd && nvm_sel && state_reg == ST_ARG);
  COV_ROW_FIRST: cover property (@(posedge i_mclk) data_acc && row_first);
  COV_WINDOW: cover property (@(posedge i_mclk) data_acc && win_en_reg);
endmodule // lcd_command_decoder

/* sim/host_model.sv */
`timescale 1ns/1ps
// ****************************************
// Host side: APB master issuing bytes
// ****************************************
module host_model
  import lcd_cmd_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  // Idle cycle first, so two calls never drive psel in one time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control byte: select low; the byte is sent as given, defined code or not
  task automatic cmd(input logic [7:0] b);
    logic [31:0] q;
    xfer(1'b1, OFF_HOST_CMD, {24'h0, b}, q);
  endtask
  // Data byte: select high
  task automatic dat();
    logic [31:0] q;
    xfer(1'b1, OFF_HOST_DATA, $urandom, q);
  endtask
endmodule // host_model

/* sim/tb.sv */
`timescale 1ns/1ps
// ****************************************
// Command decoder bench
// ****************************************
module tb;
  import lcd_cmd_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_onoff_mode = 1'b0;
  logic [7:0]  i_mux_rate = 8'h80;
  logic        psel, penable, pwrite, pready, pslverr, o_com_mirror, o_icon_show;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0]  o_ram_column;
  logic [6:0]  o_ram_row;
  logic [1:0]  o_pump_control_field;
  logic [7:0]  o_bias_pot_value, v, w;
  logic [15:0] o_line_rate;
  logic [7:0]  seq [13];
  int          num_errors = 0;
  int          tests_run = 0;
  int          c, r, m, k;
  always #20 i_mclk = ~i_mclk;
  lcd_command_decoder uut (.i_mclk, .i_resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .i_onoff_mode, .i_mux_rate, .o_ram_column,
    .o_ram_row, .o_com_mirror, .o_icon_show, .o_pump_control_field,
    .o_bias_pot_value, .o_line_rate);
  host_model host (.i_mclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.xfer(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask
  task automatic settle();
    repeat (2) @(negedge i_mclk);
  endtask
  // Sends the n low bytes of b as control bytes, highest first
  task automatic send(input logic [63:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      host.cmd(b[i*8 +: 8]);
    end
  endtask
  function automatic logic [31:0] ptr(int rr, int cc);
    return {17'h0, 7'(rr), 3'h0, 5'(cc)};
  endfunction
  // Table rate, cut down by the multiplex rate band; on/off mode unscaled
  function automatic logic [31:0] lr(int cc, logic oo, int mm);
    int n [4] = '{1420, 1730, 2110, 2570};
    int f [4] = '{570, 700, 850, 1040};
    int b;
    b = oo ? f[cc] : n[cc];
    if (oo || mm > 85) return 32'(b);
    if (mm > 64) return 32'(b * 2 / 3);
    if (mm > 43) return 32'(b / 2);
    if (mm > 32) return 32'(b / 3);
    return 32'(b / 4);
  endfunction
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(83588));
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rdchk(OFF_POINTERS, 32'h0);
    rdchk(OFF_WINDOW, 32'h7F1F_0000);
    rdchk(OFF_NVM, 32'h10);
    rdchk(OFF_STEP_CTRL, 32'h1);
    rdchk(12'h0FC, 32'h0);
    chk(o_pump_control_field, 32'h3);
    chk(o_bias_pot_value, 32'h4E);
    repeat (8) begin
      c = $urandom_range(31);
      r = $urandom_range(127);
      host.cmd({3'h0, 5'(c)});
      host.cmd({4'h6, 4'(r)});
      host.cmd({5'h0E, 3'(r >> 4)});
      rdchk(OFF_POINTERS, ptr(r, c));
      chk(o_ram_row, 32'(r));
    end
    for (c = 0; c < 4; c++) begin
      host.cmd({6'h0B, 2'(c)});
      settle();
      chk(o_pump_control_field, 32'(c));
    end
    v = 8'($urandom_range(193));
    host.cmd(8'h81);
    host.cmd(v);
    settle();
    chk(o_bias_pot_value, 32'(v));
    for (k = 0; k < 24; k++) begin
      case (k / 4)
        0: m = $urandom_range(255, 86);
        2: m = $urandom_range(85, 65);
        3: m = $urandom_range(64, 44);
        4: m = $urandom_range(43, 33);
        5: m = $urandom_range(32, 0);
        default: m = $urandom_range(255, 0);
      endcase
      @(posedge i_mclk);
      i_onoff_mode <= (k / 4 == 1);
      i_mux_rate <= 8'(m);
      host.cmd({6'h28, 2'(k % 4)});
      settle();
      chk(o_line_rate, lr(k % 4, k / 4 == 1, m));
    end
    for (c = 0; c < 8; c++) begin
      host.cmd({5'h18, 3'(c)});
      send(8'h05, 1);
      settle();
      chk({o_com_mirror, o_icon_show}, {30'h0, c[2], c[0]});
      chk(o_ram_column, c[1] ? 32'd26 : 32'd5);
    end
    send({8'hC0, 8'h88, 8'h1F, 8'h65, 8'h70}, 5);
    host.dat();
    rdchk(OFF_POINTERS, ptr(5, 31));
    send(8'h89, 1);
    host.dat();
    rdchk(OFF_POINTERS, ptr(6, 0));
    send(8'h8E, 1);
    host.dat();
    rdchk(OFF_POINTERS, ptr(5, 0));
    chk(o_ram_row, 32'h5);
    send({8'hF4, 8'h02, 8'hF6, 8'h03, 8'hF9, 8'h89, 8'h03}, 7);
    host.dat();
    rdchk(OFF_POINTERS, ptr(6, 2));
    rdchk(OFF_WINDOW, 32'h7F03_0002);
    rdchk(OFF_STEP_CTRL, 32'h11);
    send({8'hF8, 8'h03}, 2);
    host.dat();
    rdchk(OFF_POINTERS, ptr(6, 4));
    send({8'hB8, 8'h18}, 2);
    rdchk(OFF_NVM, 32'h18);
    w = ~v;
    send({8'h81, w}, 2);
    settle();
    chk(o_bias_pot_value, 32'(v));
    send({8'hB9, w}, 2);
    settle();
    chk(o_bias_pot_value, 32'(w));
    send({8'hF4, 8'h09}, 2);
    rdchk(OFF_WINDOW, 32'h7F03_0002);
    send({8'hB8, 8'h10, 8'hF5, 8'h11, 8'hF7, 8'h62, 8'hB8, 8'h18}, 8);
    rdchk(OFF_WINDOW, 32'h6203_1102);
    send(8'hE2, 1);
    settle();
    chk(o_bias_pot_value, 32'h4E);
    rdchk(OFF_NVM, 32'h10);
    rdchk(OFF_WINDOW, 32'h7F1F_0000);
    rdchk(OFF_POINTERS, 32'h0);
    // Recommended bring-up order from the host
    v = 8'($urandom_range(193));
    seq = '{8'hE2, 8'h24, 8'hC4, 8'hA3, 8'h2F, 8'hEA, 8'h81, v, 8'h89, 8'h00, 8'h70, 8'h60,
            8'hAD};
    i_onoff_mode <= 1'b0;
    i_mux_rate <= 8'h80;
    foreach (seq[k]) host.cmd(seq[k]);
    settle();
    chk(o_com_mirror, 32'h1);
    chk(o_line_rate, lr(3, 1'b0, 128));
    chk(o_bias_pot_value, 32'(v));
    rdchk(OFF_STEP_CTRL, 32'h1);
    rdchk(OFF_PANEL_CFG, 32'h0000_4F00 | 32'(v));
    rdchk(OFF_LINE_RATE, lr(3, 1'b0, 128));
    chk(pslverr, 32'h0);
    end_sim();
  end
endmodule // tb
